/* rtl/swu_crc8.sv */
// Bytewise CRC-8 update, bits taken least significant first
`timescale 1ns/1ps
`include "swu_map.svh"

module swu_crc8 (
   // Running value and new byte
   input wire logic [7:0] crc_in,
   input wire logic [7:0] data_in,
   // Updated value
   output logic [7:0] crc_out
);

   logic [7:0] stage [0:8];

   assign stage[0] = crc_in;

   // ************************************************
   // One serial step per data bit
   // ************************************************
   genvar i;
   generate
      for (i = 0; i < 8; i++) begin : g_bit
         // Feedback of top bit and incoming bit, shifted in at bit 0
         assign stage[i+1] = {stage[i][6:0], 1'b0} ^
                             ((stage[i][7] ^ data_in[i]) ? `SWU_CRC_POLY : 8'h00);
      end
   endgenerate

   assign crc_out = stage[8];

endmodule

/* rtl/swu_link.sv */
// Single-wire UART slave: datagram receive, CRC check, write strobe, read reply
`timescale 1ns/1ps
`include "swu_map.svh"

// What this block does
// - CRC-8 poly x8+x2+x+1, init zero, LSB first, over every byte but the last.
// - Serial CRC step feeds top bit xor data bit back into the low taps.
// - Last byte of a datagram is the CRC of all bytes before it.
// - Sync nibble is taken as valid; its fixed pattern enters the CRC.
// - Only datagrams with good CRC and own node address are acted on.
// - Datagram counter steps once per accepted write datagram.
// - Counter is 8 bits, wraps, and reads leave it alone.
// - One pin carries non-inverted data in both directions.
// - Line is watched except while a read reply is delayed, sent or held; bit time comes from each sync nibble.
// - Bit time measured from start-bit fall to fall between sync bits 2 and 3.
// - Valid read enables the driver and replies at the measured baud.
// - Driver turns off four bit times after the last reply stop bit.
// - Reply address byte is all ones.
// - Node address is fixed at zero; host requests carry zero.
// - Fixed address lets one write reach every device on the line.
// - Write datagram is 8 bytes of 10 bit times each.
// - Write register address carries bit 7 set; read uses plain address.
// - Device state is zero after power-up unless stated otherwise.
module swu_link #(
   parameter int CNT_W = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Shared data pin
   input wire logic sw_in,
   output logic sw_out,
   output logic sw_oe,
   // Configuration
   input wire logic [3:0] reply_delay_setting,
   // Register file side
   output logic reg_wr_stb,
   output logic reg_rd_stb,
   output logic [6:0] reg_addr,
   output logic [31:0] reg_wdata,
   input wire logic [31:0] reg_rdata,
   // Status
   output logic [7:0] dgram_count
);

   swu_pkg::swu_state_t state_reg, state_next;
   logic rx_meta_reg, rx_reg, rx_prev_reg;
   logic [CNT_W-1:0] timer_reg, timer_next;
   logic [CNT_W-1:0] bitlen_reg, bitlen_next;
   logic [CNT_W+1:0] meas_reg, meas_next;
   logic [1:0] falls_reg, falls_next;
   logic [3:0] idx_reg, idx_next;
   logic [7:0] shift_reg, shift_next;
   logic [2:0] byte_reg, byte_next;
   logic [7:0] crc_reg, crc_next;
   logic wr_reg, wr_next;
   logic addr_ok_reg, addr_ok_next;
   logic [7:0] regaddr_reg, regaddr_next;
   logic [31:0] data_reg, data_next;
   logic [7:0] cnt_reg, cnt_next;
   logic [7:0] tx_byte_reg, tx_byte_next;
   logic out_reg, out_next;
   logic oe_reg, oe_next;
   logic [7:0] dgcnt_reg, dgcnt_next;
   logic wr_stb_reg, wr_stb_next;
   logic rd_stb_reg, rd_stb_next;
   logic fall, tick, last_byte, crc_good;
   logic [7:0] rx_byte, crc_in, crc_upd, delay_bits;
   // Named copy, so that single bits of the pattern can be selected
   localparam logic [7:0] SYNC_VAL = `SWU_SYNC_BYTE;

   // ************************************************
   // Pin synchroniser
   // ************************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_meta_reg <= 1'b1;
         rx_reg <= 1'b1;
         rx_prev_reg <= 1'b1;
      end else begin
         rx_meta_reg <= sw_in;
         rx_reg <= rx_meta_reg;
         rx_prev_reg <= rx_reg;
      end
   end

   assign fall = rx_prev_reg & ~rx_reg;
   assign tick = (timer_reg == '0);

   // Sync nibble is never checked, only its fixed value is hashed
   assign rx_byte = (byte_reg == 3'h0) ? {shift_reg[7:4], SYNC_VAL[3:0]} : shift_reg;
   assign last_byte = wr_reg ? (byte_reg == `SWU_WR_LAST) : (byte_reg == `SWU_RD_LAST);
   assign crc_good = (rx_byte == crc_reg);
   assign delay_bits = (reply_delay_setting == 4'h0) ? `SWU_DELAY_UNIT :
                       8'({4'h0, reply_delay_setting} * `SWU_DELAY_UNIT);
   assign crc_in = (state_reg == swu_pkg::SWU_TX) ? tx_byte_reg : rx_byte;

   swu_crc8 u_crc (
      .crc_in(crc_reg),
      .data_in(crc_in),
      .crc_out(crc_upd)
   );

   // ************************************************
   // Datagram state machine
   // ************************************************
   always_comb begin
      state_next = state_reg;
      timer_next = tick ? bitlen_reg - 1'b1 : timer_reg - 1'b1;
      bitlen_next = bitlen_reg;
      meas_next = meas_reg;
      falls_next = falls_reg;
      idx_next = idx_reg;
      shift_next = shift_reg;
      byte_next = byte_reg;
      crc_next = crc_reg;
      wr_next = wr_reg;
      addr_ok_next = addr_ok_reg;
      regaddr_next = regaddr_reg;
      data_next = data_reg;
      cnt_next = cnt_reg;
      tx_byte_next = tx_byte_reg;
      out_next = out_reg;
      oe_next = oe_reg;
      dgcnt_next = dgcnt_reg;
      wr_stb_next = 1'b0;
      rd_stb_next = 1'b0;
      case (state_reg)
         swu_pkg::SWU_IDLE: begin
            oe_next = 1'b0;
            out_next = 1'b1;
            if (fall) begin
               state_next = swu_pkg::SWU_SYNC;
               meas_next = '0;
               falls_next = '0;
            end
         end
         swu_pkg::SWU_SYNC: begin
            meas_next = meas_reg + 1'b1;
            if (fall) begin
               falls_next = falls_reg + 1'b1;
               if (falls_reg == `SWU_SYNC_FALLS) begin
                  // Four bit times span start to the bit 2/3 fall
                  bitlen_next = meas_next[CNT_W+1:2];
                  timer_next = {1'b0, meas_next[CNT_W+1:3]};
                  idx_next = 4'h3;
                  shift_next = {SYNC_VAL[2:0], 5'h00};
                  byte_next = 3'h0;
                  crc_next = `SWU_CRC_INIT;
                  wr_next = 1'b0;
                  state_next = swu_pkg::SWU_RXBIT;
               end
            end else if (&meas_reg) begin
               // Too slow to measure: treat as error
               bitlen_next = '1;
               cnt_next = '0;
               state_next = swu_pkg::SWU_RECOVER;
            end
         end
         swu_pkg::SWU_RXBIT: begin
            if (tick) begin
               if (idx_reg != `SWU_STOP_IDX) begin
                  shift_next = {rx_reg, shift_reg[7:1]};
                  idx_next = idx_reg + 1'b1;
               end else if (!rx_reg) begin
                  cnt_next = '0;
                  state_next = swu_pkg::SWU_RECOVER;
               end else if (last_byte) begin
                  if (crc_good && addr_ok_reg) begin
                     if (wr_reg) begin
                        wr_stb_next = 1'b1;
                        dgcnt_next = dgcnt_reg + 1'b1;
                        state_next = swu_pkg::SWU_IDLE;
                     end else begin
                        rd_stb_next = 1'b1;
                        data_next = reg_rdata;
                        cnt_next = '0;
                        state_next = swu_pkg::SWU_DELAY;
                     end
                  end else if (!crc_good) begin
                     // Bad CRC forces a quiet line before resync
                     cnt_next = '0;
                     state_next = swu_pkg::SWU_RECOVER;
                  end else begin
                     state_next = swu_pkg::SWU_IDLE;
                  end
               end else begin
                  crc_next = crc_upd;
                  byte_next = byte_reg + 1'b1;
                  if (byte_reg == `SWU_BYTE_ADDR) begin
                     addr_ok_next = (rx_byte == `SWU_NODE_ADDR);
                  end
                  if (byte_reg == `SWU_BYTE_REG) begin
                     regaddr_next = rx_byte;
                     wr_next = rx_byte[`SWU_WRITE_BIT];
                  end
                  if (byte_reg > `SWU_BYTE_REG) begin
                     data_next = {data_reg[23:0], rx_byte};
                  end
                  cnt_next = '0;
                  state_next = swu_pkg::SWU_RXWAIT;
               end
            end
         end
         swu_pkg::SWU_RXWAIT: begin
            if (fall) begin
               // First sample lands mid data bit 0
               timer_next = bitlen_reg + {1'b0, bitlen_reg[CNT_W-1:1]} - 1'b1;
               idx_next = 4'h0;
               state_next = swu_pkg::SWU_RXBIT;
            end else if (tick) begin
               cnt_next = cnt_reg + 1'b1;
               if (cnt_reg == `SWU_TIMEOUT_BITS) begin
                  state_next = swu_pkg::SWU_IDLE;
               end
            end
         end
         swu_pkg::SWU_RECOVER: begin
            if (!rx_reg) begin
               cnt_next = '0;
               timer_next = bitlen_reg - 1'b1;
            end else if (tick) begin
               cnt_next = cnt_reg + 1'b1;
               if (cnt_reg == `SWU_RECOVER_BITS - 1'b1) begin
                  state_next = swu_pkg::SWU_IDLE;
               end
            end
         end
         swu_pkg::SWU_DELAY: begin
            if (tick) begin
               cnt_next = cnt_reg + 1'b1;
               if (cnt_reg == delay_bits - 1'b1) begin
                  oe_next = 1'b1;
                  out_next = 1'b0;
                  idx_next = 4'h0;
                  byte_next = 3'h0;
                  crc_next = `SWU_CRC_INIT;
                  tx_byte_next = `SWU_SYNC_BYTE;
                  state_next = swu_pkg::SWU_TX;
               end
            end
         end
         swu_pkg::SWU_TX: begin
            if (tick) begin
               if (idx_reg != `SWU_TX_STOP_IDX) begin
                  idx_next = idx_reg + 1'b1;
                  out_next = (idx_reg == `SWU_STOP_IDX) ? 1'b1 : tx_byte_reg[idx_reg[2:0]];
               end else if (byte_reg == `SWU_WR_LAST) begin
                  cnt_next = '0;
                  state_next = swu_pkg::SWU_HOLD;
               end else begin
                  crc_next = crc_upd;
                  byte_next = byte_reg + 1'b1;
                  idx_next = 4'h0;
                  out_next = 1'b0;
                  case (byte_reg)
                     3'h0: tx_byte_next = `SWU_REPLY_ADDR;
                     3'h1: tx_byte_next = {1'b0, regaddr_reg[6:0]};
                     3'h6: tx_byte_next = crc_upd;
                     default: begin
                        tx_byte_next = data_reg[31:24];
                        data_next = {data_reg[23:0], 8'h00};
                     end
                  endcase
               end
            end
         end
         swu_pkg::SWU_HOLD: begin
            out_next = 1'b1;
            if (tick) begin
               cnt_next = cnt_reg + 1'b1;
               if (cnt_reg == `SWU_RELEASE_BITS - 1'b1) begin
                  oe_next = 1'b0;
                  state_next = swu_pkg::SWU_IDLE;
               end
            end
         end
         default: begin
            oe_next = 1'b0;
            state_next = swu_pkg::SWU_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= swu_pkg::SWU_IDLE;
         timer_reg <= '0;
         bitlen_reg <= CNT_W'(`SWU_MIN_BITLEN);
         meas_reg <= '0;
         falls_reg <= '0;
         idx_reg <= '0;
         shift_reg <= '0;
         byte_reg <= '0;
         crc_reg <= `SWU_CRC_INIT;
         wr_reg <= 1'b0;
         addr_ok_reg <= 1'b0;
         regaddr_reg <= '0;
         data_reg <= '0;
         cnt_reg <= '0;
         tx_byte_reg <= '0;
         out_reg <= 1'b1;
         oe_reg <= 1'b0;
         dgcnt_reg <= '0;
         wr_stb_reg <= 1'b0;
         rd_stb_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         timer_reg <= timer_next;
         bitlen_reg <= bitlen_next;
         meas_reg <= meas_next;
         falls_reg <= falls_next;
         idx_reg <= idx_next;
         shift_reg <= shift_next;
         byte_reg <= byte_next;
         crc_reg <= crc_next;
         wr_reg <= wr_next;
         addr_ok_reg <= addr_ok_next;
         regaddr_reg <= regaddr_next;
         data_reg <= data_next;
         cnt_reg <= cnt_next;
         tx_byte_reg <= tx_byte_next;
         out_reg <= out_next;
         oe_reg <= oe_next;
         dgcnt_reg <= dgcnt_next;
         wr_stb_reg <= wr_stb_next;
         rd_stb_reg <= rd_stb_next;
      end
   end

   assign sw_out = out_reg;
   assign sw_oe = oe_reg;
   assign reg_wr_stb = wr_stb_reg;
   assign reg_rd_stb = rd_stb_reg;
   assign reg_addr = regaddr_reg[6:0];
   assign reg_wdata = data_reg;
   assign dgram_count = dgcnt_reg;

   // ************************************************
   // Checks
   // ************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_count_step: assert property (wr_stb_reg |-> dgcnt_reg == 8'($past(dgcnt_reg) + 1'b1))
      else $error("datagram counter did not step on write");
   a_read_keeps: assert property (rd_stb_reg |-> $stable(dgcnt_reg))
      else $error("read changed datagram counter");
   a_strobe_excl: assert property (!(wr_stb_reg && rd_stb_reg))
      else $error("write and read strobe together");
   a_write_flag: assert property (wr_stb_reg |-> regaddr_reg[`SWU_WRITE_BIT])
      else $error("write strobe without write address bit");
   a_read_delay: assert property (rd_stb_reg |-> state_reg == swu_pkg::SWU_DELAY && !sw_oe)
      else $error("read reply not waiting with driver off");
   a_reply_addr: assert property (state_reg == swu_pkg::SWU_TX && byte_reg == 3'h1 |-> tx_byte_reg == 8'hff)
      else $error("reply address byte not all ones");
   a_tx_driven: assert property (state_reg == swu_pkg::SWU_TX || state_reg == swu_pkg::SWU_HOLD |-> sw_oe)
      else $error("driver off during reply");
   a_hold_high: assert property (state_reg == swu_pkg::SWU_HOLD |-> sw_out)
      else $error("line not high after last stop bit");
   a_release_idle: assert property ($fell(sw_oe) |-> state_reg == swu_pkg::SWU_IDLE && $past(cnt_reg) == 8'd3)
      else $error("driver released at wrong time");
   a_crc_start: assert property (state_reg == swu_pkg::SWU_TX && byte_reg == 3'h0 |-> crc_reg == 8'h00)
      else $error("reply CRC not started from zero");
   a_idle_quiet: assert property (state_reg == swu_pkg::SWU_IDLE ##1 state_reg == swu_pkg::SWU_IDLE |-> !sw_oe)
      else $error("driver on while idle");

   c_write_done: cover property (wr_stb_reg);
   c_read_done: cover property (rd_stb_reg ##[1:1000] $rose(sw_oe));
   c_recover: cover property (state_reg == swu_pkg::SWU_RECOVER);
   c_count_wrap: cover property (wr_stb_reg && dgcnt_reg == 8'h00);

endmodule

/* rtl/swu_map.svh */
// Constants of the single-wire UART datagram engine
`ifndef SWU_MAP_SVH
`define SWU_MAP_SVH

// ************************************************
// Datagram layout
// ************************************************
`define SWU_SYNC_BYTE 8'h05
`define SWU_NODE_ADDR 8'h00
`define SWU_REPLY_ADDR 8'hff
`define SWU_WRITE_BIT 7
`define SWU_WR_LAST 3'h7
`define SWU_RD_LAST 3'h3
`define SWU_BYTE_ADDR 3'h1
`define SWU_BYTE_REG 3'h2
`define SWU_CRC_INIT 8'h00
`define SWU_CRC_POLY 8'h07

// ************************************************
// Bit timing, in bit times except SWU_MIN_BITLEN, which is in clock cycles
// ************************************************
`define SWU_STOP_IDX 4'h8
`define SWU_TX_STOP_IDX 4'h9
`define SWU_SYNC_FALLS 2'h1
`define SWU_TIMEOUT_BITS 8'd63
`define SWU_RECOVER_BITS 8'd12
`define SWU_RELEASE_BITS 8'd4
`define SWU_DELAY_UNIT 8'd8
`define SWU_MIN_BITLEN 16

`endif

/* rtl/swu_pkg.sv */
// Types shared by the single-wire UART datagram engine
package swu_pkg;

   typedef enum logic [7:0] {
      SWU_IDLE    = 8'h01,
      SWU_SYNC    = 8'h02,
      SWU_RXBIT   = 8'h04,
      SWU_RXWAIT  = 8'h08,
      SWU_RECOVER = 8'h10,
      SWU_DELAY   = 8'h20,
      SWU_TX      = 8'h40,
      SWU_HOLD    = 8'h80
   } swu_state_t;

endpackage

/* verif/swu_host.sv */
// Host UART model on the far side of the single-wire link
`timescale 1ns/1ps

module swu_host #(
   parameter int BIT_LEN = 20
) (
   // Clock
   input wire logic clk,
   // Shared line
   input wire logic line,
   output logic host_tx,
   output logic host_oe,
   // Transmit buffer control, active low
   output logic host_buf_n
);
   initial begin
      host_tx = 1'b1;
      host_oe = 1'b0;
      host_buf_n = 1'b1;
   end

   // ************************************************
   // CRC over the first n bytes
   // ************************************************
   function automatic logic [7:0] crc_of(input logic [7:0] b [8], input int n);
      logic [7:0] c;
      logic [7:0] d;
      c = 8'h00;
      for (int i = 0; i < n; i++) begin
         d = b[i];
         for (int j = 0; j < 8; j++) begin
            c = (c[7] ^ d[0]) ? ({c[6:0], 1'b0} ^ 8'h07) : {c[6:0], 1'b0};
            d = d >> 1;
         end
      end
      return c;
   endfunction

   // ************************************************
   // Transmit and receive
   // ************************************************
   task automatic drive_bit(input logic v);
      host_tx = v;
      repeat (BIT_LEN) @(posedge clk);
      #1;
   endtask

   // Last byte is replaced by the CRC; bad flips one bit of it
   task automatic send_dgram(input logic [7:0] b [8], input int n, input logic bad);
      logic [7:0] t [8];
      t = b;
      t[n-1] = crc_of(b, n - 1) ^ {7'h00, bad};
      @(posedge clk);
      #1;
      host_buf_n = 1'b0;
      host_oe = 1'b1;
      for (int i = 0; i < n; i++) begin
         drive_bit(1'b0);
         for (int j = 0; j < 8; j++) begin
            drive_bit(t[i][j]);
         end
         drive_bit(1'b1);
      end
      host_oe = 1'b0;
      host_buf_n = 1'b1;
      // Own echo was on the line all along; it is simply not decoded
   endtask

   // Waits for a start edge, samples mid-bit; ok low on timeout or framing fault
   task automatic recv_byte(output logic [7:0] v, output logic ok);
      int k;
      ok = 1'b0;
      v = 8'h00;
      for (k = 0; k < 3000 && line !== 1'b0; k++) begin
         @(posedge clk);
         #2;
      end
      if (line !== 1'b0) return;
      repeat (BIT_LEN / 2) @(posedge clk);
      #2;
      if (line !== 1'b0) return;
      for (int j = 0; j < 8; j++) begin
         repeat (BIT_LEN) @(posedge clk);
         #2;
         v[j] = line;
      end
      repeat (BIT_LEN) @(posedge clk);
      #2;
      ok = (line === 1'b1);
   endtask
endmodule

/* verif/tb.sv */
// Self-checking testbench of the single-wire UART datagram engine
`timescale 1ns/1ps

module tb;
   localparam int BL = 20;
   logic clk, rst_n;
   wire logic pin;
   logic sw_out, sw_oe, host_tx, host_oe, host_buf_n;
   logic [3:0] reply_delay_setting;
   logic reg_wr_stb, reg_rd_stb;
   logic [6:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   logic [7:0] dgram_count;
   logic [6:0] wr_addr;
   logic [31:0] wr_data;
   int err_total, num_checks, cyc, wr_seen, rd_seen, rd_time;

   // Line has a pull-up; either party pulls it only while enabled
   assign pin = (sw_oe ? sw_out : 1'b1) & (host_oe ? host_tx : 1'b1);
   // Register file stand-in: content follows address combinationally
   assign reg_rdata = {1'b0, reg_addr, 24'hc3a55a};

   swu_link #(.CNT_W(16)) u_swu_link (.clk(clk), .rst_n(rst_n), .sw_in(pin), .sw_out(sw_out),
      .sw_oe(sw_oe), .reply_delay_setting(reply_delay_setting), .reg_wr_stb(reg_wr_stb),
      .reg_rd_stb(reg_rd_stb), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .dgram_count(dgram_count));
   swu_host #(.BIT_LEN(BL)) u_swu_host (.clk(clk), .line(pin), .host_tx(host_tx), .host_oe(host_oe),
      .host_buf_n(host_buf_n));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // Strobe monitor; strobes stand one cycle only
   initial begin
      cyc = 0;
      wr_seen = 0;
      rd_seen = 0;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (reg_wr_stb === 1'b1) begin
         wr_seen <= wr_seen + 1;
         wr_addr <= reg_addr;
         wr_data <= reg_wdata;
      end
      if (reg_rd_stb === 1'b1) begin
         rd_seen <= rd_seen + 1;
         rd_time <= cyc;
      end
   end

   // ************************************************
   // Helpers
   // ************************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic idle(input int bits);
      repeat (bits * BL) @(posedge clk);
      #1;
   endtask

   task automatic send_write(input logic [7:0] node, input logic [6:0] a, input logic [31:0] d, input logic bad);
      logic [7:0] b [8];
      b = '{8'h05, node, {1'b1, a}, d[31:24], d[23:16], d[15:8], d[7:0], 8'h00};
      u_swu_host.send_dgram(b, 8, bad);
   endtask

   // ************************************************
   // Scenarios
   // ************************************************
   task automatic sc_reset();
      check(dgram_count, 8'h00);
      check(sw_oe, 1'b0);
      check(sw_out, 1'b1);
      check({reg_wr_stb, reg_rd_stb}, 2'b00);
   endtask

   // Two writes back to back, then a gap
   task automatic sc_write_pair();
      logic [7:0] c0;
      int n0;
      c0 = dgram_count;
      n0 = wr_seen;
      send_write(8'h00, 7'h10, 32'h1234_5678, 1'b0);
      check(wr_addr, 7'h10);
      check(wr_data, 32'h1234_5678);
      send_write(8'h00, 7'h7f, 32'h8001_00fe, 1'b0);
      idle(20);
      check(wr_seen, n0 + 2);
      check(wr_addr, 7'h7f);
      check(wr_data, 32'h8001_00fe);
      check(dgram_count, 8'(c0 + 8'h02));
   endtask

   // Bad CRC or foreign address: nothing happens
   task automatic sc_reject(input logic [7:0] node, input logic bad);
      logic [7:0] c0;
      int n0;
      c0 = dgram_count;
      n0 = wr_seen;
      send_write(node, 7'h22, 32'hdead_beef, bad);
      idle(20);
      check(wr_seen, n0);
      check(dgram_count, c0);
      check(sw_oe, 1'b0);
   endtask

   task automatic sc_read(input logic [3:0] setting, input logic [6:0] a);
      logic [7:0] b [8];
      logic [7:0] exp [8];
      logic [7:0] v;
      logic ok;
      logic [7:0] c0;
      int r0, k, dexp, n0;
      c0 = dgram_count;
      r0 = rd_seen;
      n0 = wr_seen;
      reply_delay_setting = setting;
      dexp = 8 * ((setting == 4'h0) ? 1 : setting) * BL;
      b = '{8'h05, 8'h00, {1'b0, a}, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
      u_swu_host.send_dgram(b, 4, 1'b0);
      for (k = 0; k < 4000 && sw_oe !== 1'b1; k++) begin
         @(posedge clk);
         #2;
      end
      check(rd_seen, r0 + 1);
      check((cyc - rd_time >= dexp - 4) && (cyc - rd_time <= dexp + 4), 1'b1);
      check(sw_oe, 1'b1);
      if (sw_oe !== 1'b1) give_verdict();
      exp = '{8'h05, 8'hff, {1'b0, a}, {1'b0, a}, 8'hc3, 8'ha5, 8'h5a, 8'h00};
      exp[7] = u_swu_host.crc_of(exp, 7);
      for (int i = 0; i < 8; i++) begin
         u_swu_host.recv_byte(v, ok);
         check(ok, 1'b1);
         check(v, exp[i]);
         if (ok !== 1'b1) give_verdict();
      end
      for (k = 0; k < 500 && sw_oe === 1'b1; k++) begin
         @(posedge clk);
         #2;
      end
      check((k >= BL / 2 + 4 * BL - 3) && (k <= BL / 2 + 4 * BL + 3), 1'b1);
      check(dgram_count, c0);
      check(wr_seen, n0);
      idle(4);
   endtask

   // ************************************************
   // Main sequence
   // ************************************************
   initial begin
      err_total = 0;
      num_checks = 0;
      rst_n = 1'b0;
      reply_delay_setting = 4'h0;
      repeat (10) @(posedge clk);
      #1;
      rst_n = 1'b1;
      repeat (5) @(posedge clk);
      #1;
      sc_reset();
      sc_write_pair();
      sc_reject(8'h00, 1'b1);
      sc_reject(8'h01, 1'b0);
      sc_read(4'h0, 7'h05);
      sc_read(4'h3, 7'h6c);
      // Resync after the reply proves the line is watched again
      sc_write_pair();
      give_verdict();
   end
endmodule
